// file: design/dcz_pkg.sv
// constants, field layouts and carrier types for one dma channel
// assumes a single 100 MHz clock, an axi4-lite register port and an ahb master port
package dcz_pkg;

   localparam int CNT_WIDTH   = 24;
   localparam int BURST_MAX   = 32;

   // register byte offsets
   localparam logic [7:0] OFS_SRC     = 8'h00;
   localparam logic [7:0] OFS_DST     = 8'h04;
   localparam logic [7:0] OFS_CNT     = 8'h08;
   localparam logic [7:0] OFS_CFG     = 8'h0c;
   localparam logic [7:0] OFS_STAT    = 8'h10;
   localparam logic [7:0] OFS_SRC_RLD = 8'h14;
   localparam logic [7:0] OFS_DST_RLD = 8'h18;
   localparam logic [7:0] OFS_CNT_RLD = 8'h1c;

   // status bit positions
   localparam int STAT_ACTIVE  = 0;
   localparam int STAT_RELOAD  = 1;
   localparam int STAT_CTZ     = 2;
   localparam int STAT_BUS_ERR = 3;

   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK = 32'h001f_fff3;

   // request codes
   localparam logic [5:0] REQ_MEM2MEM = 6'h00;
   localparam logic [5:0] TX_FLAG     = 6'h20;

   // fixed peripheral fifo addresses: base plus slot per low four bits of the request code
   localparam logic [31:0] PERIPH_BASE       = 32'h4000_0000;
   localparam int          PERIPH_SLOT_SHIFT = 12;

   localparam logic [1:0] HTRANS_IDLE    = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0] AXI_OKAY       = 2'h0;
   localparam logic [1:0] AXI_SLVERR     = 2'h2;

   typedef struct packed {
      logic [10:0] rsv_hi;
      logic [4:0]  brst;     // burst bytes minus one
      logic        dstinc;
      logic [1:0]  dstwd;
      logic        srcinc;
      logic [1:0]  srcwd;
      logic [5:0]  reqsel;
      logic [1:0]  rsv_lo;
      logic        rlden;
      logic        chen;
   } dcz_cfg_t;

   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
   } dcz_ahb_req_t;

endpackage

// file: design/dcz_reqsel_map.sv
// request code to address and increment mapping
// assumes the code is stable while the channel is active
`timescale 1ns/100ps
module dcz_reqsel_map
   import dcz_pkg::*;
(
   input  wire logic [5:0]  reqsel,
   input  wire logic        srcinc,
   input  wire logic        dstinc,
   input  wire logic [31:0] src_reg,
   input  wire logic [31:0] dst_reg,
   output logic [31:0]      src_addr,
   output logic [31:0]      dst_addr,
   output logic             src_inc,
   output logic             dst_inc,
   output logic             mem2mem,
   output logic             code_ok
);
   logic        is_rx;
   logic        is_tx;
   logic [31:0] periph_addr;

   always_comb begin
      unique case (reqsel[4:0])
         5'h01, 5'h02, 5'h04, 5'h05, 5'h07, 5'h08: is_rx = ~reqsel[5];
         default:                                  is_rx = 1'b0;
      endcase
      unique case (reqsel[4:0])
         5'h01, 5'h02, 5'h04, 5'h05, 5'h07, 5'h08: is_tx = reqsel[5];
         default:                                  is_tx = 1'b0;
      endcase
   end

   assign mem2mem     = (reqsel == REQ_MEM2MEM);
   assign code_ok     = mem2mem | is_rx | is_tx;
   assign periph_addr = PERIPH_BASE + (32'(reqsel[3:0]) << PERIPH_SLOT_SHIFT);
   assign src_addr    = is_rx ? periph_addr : src_reg;
   assign dst_addr    = is_tx ? periph_addr : dst_reg;
   assign src_inc     = srcinc & ~is_rx;
   assign dst_inc     = dstinc & ~is_tx;
endmodule

// file: design/dcz_access_size.sv
// one access size from a width code and the bytes available
// no alignment check: software keeps addresses aligned to the width
`timescale 1ns/100ps
module dcz_access_size
   import dcz_pkg::*;
(
   input  wire logic [1:0]           width,
   input  wire logic [CNT_WIDTH-1:0] avail,
   output logic [2:0]                size_bytes,
   output logic [2:0]                hsize
);
   always_comb begin
      if (width[1] && avail >= CNT_WIDTH'(4)) begin
         size_bytes = 3'h4;
         hsize      = 3'h2;
      end else if ((width != 2'h0) && avail >= CNT_WIDTH'(2)) begin
         size_bytes = 3'h2;   // halfword width, or a word width narrowed to what remains
         hsize      = 3'h1;
      end else begin
         size_bytes = 3'h1;
         hsize      = 3'h0;
      end
   end
endmodule

// file: design/dcz_channel.sv
// one dma channel: register file, address build, burst read then burst write
// assumes an external arbiter answering chan_request with chan_grant
// and a non-pipelined ahb view: one access in flight, address then data phase
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module dcz_channel
   import dcz_pkg::*;
#(
   parameter int DEPTH = BURST_MAX
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        periph_req,
   output logic             chan_request,
   input  wire logic        chan_grant,
   output dcz_ahb_req_t     ahb_out,
   input  wire logic [31:0] hrdata,
   input  wire logic        hready,
   input  wire logic        hresp,
   output logic             ctz_event,
   output logic             reload_event
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_RD_CHK, ST_RD_A, ST_RD_D, ST_WR_CHK, ST_WR_A, ST_WR_D, ST_END
   } dcz_state_t;

   dcz_state_t           state_q;
   dcz_cfg_t             cfg_q;
   logic [31:0]          src_q, dst_q, src_rld_q, dst_rld_q;
   logic [CNT_WIDTH-1:0] cnt_q, cnt_rld_q;
   logic [3:0]           stat_q;
   logic [7:0]           fifo_q [DEPTH];
   logic [5:0]           rd_n_q, wr_n_q;
   logic [2:0]           acc_q;
   dcz_ahb_req_t         ahb_q;

   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        aw_v_q, w_v_q, b_v_q, r_v_q;
   logic [1:0]  b_resp_q, r_resp_q;
   logic [31:0] r_data_q;

   logic [31:0]          src_addr, dst_addr, rd_word, wr_word, hw_word;
   logic                 src_inc, dst_inc, mem2mem, code_ok;
   logic [5:0]           limit, burst_left;
   logic [CNT_WIDTH-1:0] rd_avail, wr_avail;
   logic [2:0]           rd_sz, rd_hsize, wr_sz, wr_hsize;
   logic                 wr_do, rd_ok, err_beat, at_end, ctz, go;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            old[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return old;
   endfunction

   dcz_reqsel_map u_map (
      .reqsel   (cfg_q.reqsel),
      .srcinc   (cfg_q.srcinc),
      .dstinc   (cfg_q.dstinc),
      .src_reg  (src_q),
      .dst_reg  (dst_q),
      .src_addr (src_addr),
      .dst_addr (dst_addr),
      .src_inc  (src_inc),
      .dst_inc  (dst_inc),
      .mem2mem  (mem2mem),
      .code_ok  (code_ok)
   );

   // burst cap applies to both halves
   assign limit      = 6'(cfg_q.brst) + 6'h1;
   assign burst_left = limit - rd_n_q;
   assign rd_avail   = (cnt_q < CNT_WIDTH'(burst_left)) ? cnt_q : CNT_WIDTH'(burst_left);
   assign wr_avail   = CNT_WIDTH'(rd_n_q - wr_n_q);

   dcz_access_size u_rd_size (
      .width      (cfg_q.srcwd),
      .avail      (rd_avail),
      .size_bytes (rd_sz),
      .hsize      (rd_hsize)
   );

   dcz_access_size u_wr_size (
      .width      (cfg_q.dstwd),
      .avail      (wr_avail),
      .size_bytes (wr_sz),
      .hsize      (wr_hsize)
   );

   // ---------------- axi4-lite slave ----------------
   assign s_axi_awready = ~aw_v_q;
   assign s_axi_wready  = ~w_v_q;
   assign s_axi_arready = ~r_v_q;
   assign s_axi_bvalid  = b_v_q;
   assign s_axi_bresp   = b_resp_q;
   assign s_axi_rvalid  = r_v_q;
   assign s_axi_rresp   = r_resp_q;
   assign s_axi_rdata   = r_data_q;

   assign wr_do = aw_v_q & w_v_q & ~b_v_q;
   assign rd_ok = s_axi_arvalid & ~r_v_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_v_q    <= 1'b0;
         w_v_q     <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= RST_WORD;
         w_strb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_v_q) begin
            aw_v_q    <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_v_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_v_q) begin
            w_v_q    <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_do) begin
            w_v_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_v_q    <= 1'b0;
         b_resp_q <= AXI_OKAY;
      end else if (wr_do) begin
         b_v_q    <= 1'b1;
         b_resp_q <= (aw_addr_q > OFS_CNT_RLD || aw_addr_q[1:0] != 2'h0) ? AXI_SLVERR
                                                                        : AXI_OKAY;
      end else if (s_axi_bready) begin
         b_v_q <= 1'b0;
      end
   end

   always_comb begin
      rd_word = RST_WORD;
      unique case (s_axi_araddr)
         OFS_SRC:     rd_word = src_q;
         OFS_DST:     rd_word = dst_q;
         OFS_CNT:     rd_word = 32'(cnt_q);
         OFS_CFG:     rd_word = cfg_q;
         OFS_STAT:    rd_word = 32'(stat_q);
         OFS_SRC_RLD: rd_word = src_rld_q;
         OFS_DST_RLD: rd_word = dst_rld_q;
         OFS_CNT_RLD: rd_word = 32'(cnt_rld_q);
         default:     rd_word = RST_WORD;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_v_q    <= 1'b0;
         r_data_q <= RST_WORD;
         r_resp_q <= AXI_OKAY;
      end else if (rd_ok) begin
         r_v_q    <= 1'b1;
         r_data_q <= rd_word;
         r_resp_q <= (s_axi_araddr > OFS_CNT_RLD || s_axi_araddr[1:0] != 2'h0) ? AXI_SLVERR
                                                                              : AXI_OKAY;
      end else if (s_axi_rready) begin
         r_v_q <= 1'b0;
      end
   end

   // ---------------- channel engine ----------------
   assign err_beat = hready & hresp & (state_q == ST_RD_D || state_q == ST_WR_D);
   assign at_end   = (state_q == ST_END);
   assign ctz      = at_end & (cnt_q == '0);
   assign go       = chan_request & chan_grant;
   // memory to memory asks as soon as it is active, others wait for their peripheral
   assign chan_request = (state_q == ST_IDLE) & stat_q[STAT_ACTIVE] & cfg_q.chen & code_ok
                         & (mem2mem | periph_req);
   assign ahb_out      = ahb_q;
   assign ctz_event    = ctz;
   assign reload_event = ctz & cfg_q.rlden;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE:   if (go) state_q <= ST_RD_CHK;
            ST_RD_CHK: state_q <= (cnt_q != '0 && rd_n_q < limit) ? ST_RD_A : ST_WR_CHK;
            ST_RD_A:   if (hready) state_q <= ST_RD_D;
            ST_RD_D:   if (hready) state_q <= hresp ? ST_IDLE : ST_RD_CHK;
            ST_WR_CHK: state_q <= (wr_n_q < rd_n_q) ? ST_WR_A : ST_END;
            ST_WR_A:   if (hready) state_q <= ST_WR_D;
            ST_WR_D:   if (hready) state_q <= hresp ? ST_IDLE : ST_WR_CHK;
            ST_END:    state_q <= ST_IDLE;
         endcase
      end
   end

   // write data placed on the lanes the address selects
   always_comb begin
      hw_word = RST_WORD;
      for (int k = 0; k < 4; k++) begin
         if (3'(k) < wr_sz) begin
            hw_word[8*(2'(dst_addr[1:0] + 2'(k))) +: 8] = fifo_q[5'(wr_n_q + 6'(k))];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ahb_q <= '{haddr: RST_WORD, htrans: HTRANS_IDLE, hwrite: 1'b0, hsize: 3'h0,
                    hwdata: RST_WORD};
         acc_q <= 3'h0;
      end else if (state_q == ST_RD_CHK && cnt_q != '0 && rd_n_q < limit) begin
         ahb_q.haddr  <= src_addr;
         ahb_q.htrans <= HTRANS_NONSEQ;
         ahb_q.hwrite <= 1'b0;
         ahb_q.hsize  <= rd_hsize;
         acc_q        <= rd_sz;
      end else if (state_q == ST_WR_CHK && wr_n_q < rd_n_q) begin
         ahb_q.haddr  <= dst_addr;
         ahb_q.htrans <= HTRANS_NONSEQ;
         ahb_q.hwrite <= 1'b1;
         ahb_q.hsize  <= wr_hsize;
         ahb_q.hwdata <= hw_word;
         acc_q        <= wr_sz;
      end else if ((state_q == ST_RD_A || state_q == ST_WR_A) && hready) begin
         ahb_q.htrans <= HTRANS_IDLE;
      end
   end

   // buffer fill and drain counts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_n_q <= 6'h0;
         wr_n_q <= 6'h0;
      end else if (state_q == ST_IDLE) begin
         rd_n_q <= 6'h0;
         wr_n_q <= 6'h0;
      end else if (state_q == ST_RD_D && hready && !hresp) begin
         rd_n_q <= rd_n_q + 6'(acc_q);
      end else if (state_q == ST_WR_D && hready && !hresp) begin
         wr_n_q <= wr_n_q + 6'(acc_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (state_q == ST_RD_D && hready && !hresp) begin
         for (int k = 0; k < 4; k++) begin
            if (3'(k) < acc_q) begin
               fifo_q[5'(rd_n_q + 6'(k))] <= hrdata[8*(2'(ahb_q.haddr[1:0] + 2'(k))) +: 8];
            end
         end
      end
   end

   // address and count registers: hardware update wins over a software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_q <= RST_WORD;
         dst_q <= RST_WORD;
         cnt_q <= '0;
      end else if (ctz && cfg_q.rlden) begin
         src_q <= src_rld_q;
         dst_q <= dst_rld_q;
         cnt_q <= cnt_rld_q;
      end else if (state_q == ST_RD_D && hready && !hresp) begin
         if (src_inc) src_q <= src_q + 32'(acc_q);
         cnt_q <= cnt_q - CNT_WIDTH'(acc_q);
      end else if (state_q == ST_WR_D && hready && !hresp) begin
         if (dst_inc) dst_q <= dst_q + 32'(acc_q);
      end else if (wr_do) begin
         if (aw_addr_q == OFS_SRC) src_q <= merge(src_q, w_data_q, w_strb_q);
         if (aw_addr_q == OFS_DST) dst_q <= merge(dst_q, w_data_q, w_strb_q);
         if (aw_addr_q == OFS_CNT) cnt_q <= CNT_WIDTH'(merge(32'(cnt_q), w_data_q, w_strb_q));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_rld_q <= RST_WORD;
         dst_rld_q <= RST_WORD;
         cnt_rld_q <= '0;
      end else if (wr_do) begin
         if (aw_addr_q == OFS_SRC_RLD) src_rld_q <= merge(src_rld_q, w_data_q, w_strb_q);
         if (aw_addr_q == OFS_DST_RLD) dst_rld_q <= merge(dst_rld_q, w_data_q, w_strb_q);
         if (aw_addr_q == OFS_CNT_RLD) begin
            cnt_rld_q <= CNT_WIDTH'(merge(32'(cnt_rld_q), w_data_q, w_strb_q));
         end
      end
   end

   // configuration; finishing or a bus error drops the enable after any software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= dcz_cfg_t'(RST_WORD);
      end else begin
         if (wr_do && aw_addr_q == OFS_CFG) begin
            cfg_q <= dcz_cfg_t'(merge(cfg_q, w_data_q, w_strb_q) & CFG_WMASK);
         end
         if ((ctz && !cfg_q.rlden) || err_beat) begin
            cfg_q.chen <= 1'b0;
         end
      end
   end

   // active status follows enable between bursts; a disable mid-burst waits for its end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q[STAT_ACTIVE] <= 1'b0;
      end else if (err_beat) begin
         stat_q[STAT_ACTIVE] <= 1'b0;
      end else if (at_end) begin
         // a reload keeps the channel running on the same configuration
         stat_q[STAT_ACTIVE] <= cfg_q.chen & ~(ctz & ~cfg_q.rlden);
      end else if (state_q == ST_IDLE) begin
         stat_q[STAT_ACTIVE] <= cfg_q.chen;
      end
   end

   // sticky events, write one to clear; a new event in the clearing cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q[3:1] <= 3'h0;
      end else begin
         stat_q[STAT_RELOAD]  <= (ctz & cfg_q.rlden) | (stat_q[STAT_RELOAD] &
                                 ~(wr_do & aw_addr_q == OFS_STAT & w_strb_q[0]
                                   & w_data_q[STAT_RELOAD]));
         stat_q[STAT_CTZ]     <= ctz | (stat_q[STAT_CTZ] &
                                 ~(wr_do & aw_addr_q == OFS_STAT & w_strb_q[0]
                                   & w_data_q[STAT_CTZ]));
         stat_q[STAT_BUS_ERR] <= err_beat | (stat_q[STAT_BUS_ERR] &
                                 ~(wr_do & aw_addr_q == OFS_STAT & w_strb_q[0]
                                   & w_data_q[STAT_BUS_ERR]));
      end
   end

endmodule

// file: tb/dcz_chk.sv
// checker on the dma channel ports: ahb access shape, count-to-zero pulses
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module dcz_chk
   import dcz_pkg::*;
#(
   parameter int DEPTH = BURST_MAX
)(
   input wire logic         aclk,
   input wire logic         aresetn,
   input wire logic         chan_request,
   input wire logic         chan_grant,
   input wire dcz_ahb_req_t ahb_out,
   input wire logic         hready,
   input wire logic         ctz_event,
   input wire logic         reload_event
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_addr;
      ahb_out.htrans == HTRANS_NONSEQ;
   endsequence
   sequence s_taken;
      s_addr ##0 hready;
   endsequence
   sequence s_stall;
      s_addr ##0 !hready;
   endsequence
   chk_grant_start: assert property (chan_request && chan_grant |-> ##[1:4]
      (ahb_out.htrans == HTRANS_NONSEQ || ctz_event)) else $error("no access after grant");
   chk_addr_hold: assert property (s_stall |=> s_addr ##0 $stable(ahb_out))
      else $error("address phase moved while stalled");
   chk_one_flight: assert property (s_taken |=> (ahb_out.htrans == HTRANS_IDLE) [*2])
      else $error("access during data phase");
   chk_size_cap: assert property (s_addr |-> ahb_out.hsize <= 3'h2)
      else $error("access wider than a word");
   chk_addr_align: assert property (s_addr |->
      (ahb_out.haddr & ((32'h1 << ahb_out.hsize) - 32'h1)) == 32'h0)
      else $error("unaligned access");
   chk_busy_quiet: assert property (s_addr |-> !chan_request)
      else $error("request raised mid burst");
   chk_reload_ctz: assert property (reload_event |-> ctz_event)
      else $error("reload without count-to-zero");
   chk_ctz_pulse: assert property (ctz_event |=> !ctz_event)
      else $error("count-to-zero longer than a cycle");
   chk_ctz_end: assert property (ctz_event |-> ahb_out.htrans == HTRANS_IDLE)
      else $error("count-to-zero inside an access");
   chk_done_quiet: assert property (ctz_event && !reload_event |=> !chan_request [*4])
      else $error("request after final count-to-zero");
endmodule
bind dcz_channel dcz_chk #(.DEPTH(DEPTH)) i_dcz_chk (
   .aclk, .aresetn, .chan_request, .chan_grant, .ahb_out, .hready, .ctz_event, .reload_event
);

// file: tb/dcz_ahb_mem.sv
// ahb memory and peripheral fifo model on the far side of the channel
// assumes a non-pipelined master; stall comes from the bench, any cycle
`timescale 1ns/100ps
module dcz_ahb_mem
   import dcz_pkg::*;
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire dcz_ahb_req_t ahb_out,
   input  wire logic         stall,
   output logic [31:0]       hrdata,
   output logic              hready
);
   logic [7:0]   mem [logic [31:0]];
   logic         dph_q = 1'b0;
   dcz_ahb_req_t dat_q;
   logic [31:0]  last_q = 32'h0;
   function automatic logic [7:0] pat(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   function automatic logic [31:0] rd_word(input logic [31:0] a);
      logic [31:0] b;
      for (int k = 0; k < 4; k++) begin
         b = {a[31:2], 2'h0} + k;
         rd_word[8*k +: 8] = mem.exists(b) ? mem[b] : pat(b);
      end
   endfunction
   assign hready = !stall;
   // released bus shows the inverse, so a stale capture cannot pass
   assign hrdata = dph_q ? rd_word(dat_q.haddr) : ~last_q;
   always @(posedge aclk) begin
      if (!aresetn)
         dph_q <= 1'b0;
      else if (hready) begin
         if (dph_q && dat_q.hwrite)
            for (int k = 0; k < (1 << dat_q.hsize); k++)
               mem[dat_q.haddr + k] = ahb_out.hwdata[8*((dat_q.haddr[1:0] + k) % 4) +: 8];
         if (dph_q)
            last_q <= hrdata;
         dph_q <= ahb_out.htrans == HTRANS_NONSEQ;
         dat_q <= ahb_out;
      end
   end
endmodule

// file: tb/dcz_channel_tb_top.sv
// bench for one dma channel: axi4-lite master, access list model, scenarios
// assumes the ahb model beside the design and the bound checker
`timescale 1ns/100ps
module dcz_channel_tb_top import dcz_pkg::*;;
   logic         aclk, awr, wrr, bv, arr, rv, hready, req, ctz, rld;
   logic         aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic         grant = 1'b0, preq = 1'b0, stall = 1'b0;
   logic [7:0]   awa = 8'h0, ara = 8'h0;
   logic [31:0]  wd = 32'h0, rdat, hrdata, rdv, rl_s, rl_d, rl_c, lfsr = 32'hb14b2426;
   logic [1:0]   br, rr, rrv;
   dcz_ahb_req_t ahb;
   int           fails, compares, ctz_n, rl_n, g[6];
   logic [35:0]  exp_q[$];
   int           codes[12] = '{1, 2, 4, 5, 7, 8, 'h21, 'h22, 'h24, 'h25, 'h27, 'h28};
   dcz_channel i_dcz_channel (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .periph_req(preq), .chan_request(req), .chan_grant(grant), .ahb_out(ahb),
      .hrdata(hrdata), .hready(hready), .hresp(1'b0), .ctz_event(ctz), .reload_event(rld));
   dcz_ahb_mem i_dcz_ahb_mem (.aclk(aclk), .aresetn(aresetn), .ahb_out(ahb), .stall(stall),
      .hrdata(hrdata), .hready(hready));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   always @(posedge aclk) begin
      lfsr <= lfsr_next(lfsr);
      {grant, preq, stall} <= {lfsr[3], lfsr[7], lfsr[11] & lfsr[12]};
   end
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic close_out;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {awa, wd} <= {a, d};
      {awv, wv, bre} <= 3'h7;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
      end while (!bv);
      chk(br, ((a > OFS_CNT_RLD) || (a[1:0] != 2'h0)) ? AXI_SLVERR : AXI_OKAY);
      bre <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      ara <= a;
      {arv, rre} <= 2'h3;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      {d, r} = {rdat, rr};
      rre <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a, rdv, rrv);
      chk(rdv, e);
   endtask
   // expected access list: reads of a burst, then writes draining the same bytes
   task automatic plan(input int rq, si, di, sw, dw, bs, input logic [31:0] s, d, input int n);
      logic [31:0] pa;
      int b, k, z;
      pa = PERIPH_BASE + (32'(rq & 15) << PERIPH_SLOT_SHIFT);
      // fixed fifo slot; a concatenation here would spill the address into the flag
      if (rq != 0 && rq < 'h20) begin
         s  = pa;
         si = 0;
      end
      if (rq >= 'h20) begin
         d  = pa;
         di = 0;
      end
      while (n > 0) begin
         b = (bs < n) ? bs : n;
         for (k = b; k > 0; k -= z) begin
            for (z = (sw == 0) ? 1 : (sw == 1) ? 2 : 4; z > k; z /= 2);
            exp_q.push_back({1'b0, 3'(z / 2), s});
            s += si ? z : 0;
            n -= z;
         end
         for (k = b; k > 0; k -= z) begin
            for (z = (dw == 0) ? 1 : (dw == 1) ? 2 : 4; z > k; z /= 2);
            exp_q.push_back({1'b1, 3'(z / 2), d});
            d += di ? z : 0;
         end
      end
   endtask
   always @(posedge aclk) if (aresetn) begin
      if (ahb.htrans == HTRANS_NONSEQ && hready)
         chk({ahb.hwrite, ahb.hsize, ahb.haddr}, exp_q.size() ? exp_q.pop_front() : '1);
      if (ctz) begin
         ctz_n++;
         chk(exp_q.size(), 0);
         if (rld) rl_n++;
         if (rld) plan(g[0], g[1], g[2], g[3], g[4], g[5], rl_s, rl_d, rl_c);
      end
   end
   task automatic run(input int rq, si, di, sw, dw, bs, input logic [31:0] s, d, input int n, rl);
      dcz_cfg_t c;
      int t;
      t = ctz_n + 1 + rl;
      g = '{rq, si, di, sw, dw, bs};
      wr(OFS_STAT, 32'hf);
      wr(OFS_SRC, s);
      wr(OFS_DST, d);
      wr(OFS_CNT, n);
      plan(rq, si, di, sw, dw, bs, s, d, n);
      c = '{rsv_hi: 11'h0, brst: 5'(bs - 1), dstinc: di[0], dstwd: 2'(dw), srcinc: si[0],
            srcwd: 2'(sw), reqsel: 6'(rq), rsv_lo: 2'h0, rlden: rl[0], chen: 1'b1};
      wr(OFS_CFG, c);
      while (rl_n < rl) @(posedge aclk);
      if (rl) rdc(OFS_STAT, 32'h7);
      c.rlden = 1'b0;
      if (rl) wr(OFS_CFG, c);
      while (ctz_n < t) @(posedge aclk);
      rdc(OFS_CNT, 32'h0);
      rdc(OFS_CFG, {c[31:1], 1'b0});
      rdc(OFS_STAT, rl ? 32'h6 : 32'h4);
      $display("test code %0h done", rq);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(OFS_STAT, RST_WORD);
      rd(8'h20, rdv, rrv);
      chk({rdv, rrv}, {32'h0, AXI_SLVERR});
      wr(8'h22, 32'hffff_ffff);
      $display("test map done");
      run(0, 1, 1, 2, 1, 4, 32'h1000, 32'h2000, 7, 0);
      for (int i = 0; i < 7; i++)
         chk(i_dcz_ahb_mem.mem[32'h2000 + i], i_dcz_ahb_mem.pat(32'h1000 + i));
      run(0, 1, 1, 3, 3, 32, 32'h1100, 32'h2100, 40, 0);
      run(0, 0, 1, 0, 2, 1, 32'h1200, 32'h2200, 3, 0);
      foreach (codes[i]) run(codes[i], 1, 1, 1, 1, 4, 32'h3000, 32'h3100, 4, 0);
      {rl_s, rl_d, rl_c} = {32'h1400, 32'h2400, 32'd12};
      wr(OFS_SRC_RLD, rl_s);
      wr(OFS_DST_RLD, rl_d);
      wr(OFS_CNT_RLD, rl_c);
      run(0, 1, 1, 2, 2, 8, 32'h1300, 32'h2300, 8, 1);
      close_out;
   end
   initial begin
      #300000;
      fails++;
      close_out;
   end
endmodule
